// *** pkg/fwp_pkg.sv ***
// Constants shared by the flash write-protect and suspend timing block
package fwp_pkg;
	localparam int CLK_HZ      = 20000000;
	localparam int CYC_PER_MS  = CLK_HZ / 1000;
	localparam int SUSP_LAT_NS = 30000;
	localparam int SUSP_LAT_CYC = SUSP_LAT_NS * (CLK_HZ / 1000000) / 1000;
	localparam int RES_GAP_NS  = 300;
	localparam int RES_GAP_CYC = (RES_GAP_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int PROG_TYP_MS  = 2;
	localparam int PROG_MAX_MS  = 3;
	localparam int ERASE_TYP_MS = 8;
	localparam int ERASE_MAX_MS = 12;
	localparam int OP_W   = 18;
	localparam int SUS_W  = 10;
	localparam int ADDR_W = 19;

	localparam logic [19:0] ARRAY_BYTES = 20'h80000;
	localparam logic [19:0] SZ_4K   = 20'h01000;
	localparam logic [19:0] SZ_8K   = 20'h02000;
	localparam logic [19:0] SZ_16K  = 20'h04000;
	localparam logic [19:0] SZ_32K  = 20'h08000;
	localparam logic [19:0] SZ_64K  = 20'h10000;
	localparam logic [19:0] SZ_128K = 20'h20000;
	localparam logic [19:0] SZ_256K = 20'h40000;

	// Serial command codes
	localparam logic [7:0] OPC_UNLOCK  = 8'h06;
	localparam logic [7:0] OPC_LOCK    = 8'h04;
	localparam logic [7:0] OPC_WRSTAT  = 8'h01;
	localparam logic [7:0] OPC_PROG    = 8'h02;
	localparam logic [7:0] OPC_ERS4K   = 8'h20;
	localparam logic [7:0] OPC_ERS32K  = 8'h52;
	localparam logic [7:0] OPC_ERS64K  = 8'hD8;
	localparam logic [7:0] OPC_CHIP_A  = 8'hC7;
	localparam logic [7:0] OPC_CHIP_B  = 8'h60;
	localparam logic [7:0] OPC_SLEEP   = 8'hB9;
	localparam logic [7:0] OPC_RELEASE = 8'hAB;
	localparam logic [7:0] OPC_SUSPEND = 8'h75;
	localparam logic [7:0] OPC_RESUME  = 8'h7A;

	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CTRL   = 8'h04;
	localparam logic [7:0] REG_ADDR   = 8'h08;
	localparam logic       CTRL_RST   = 1'b0;
	localparam logic [4:0] RANGE_RST  = 5'h00;

	typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_SUSPENDING, ST_SUSPENDED} fwp_st_e;
endpackage : fwp_pkg

// *** rtl/fwp_top.sv ***
// Serial flash write protection, command gating and program/erase timing
// Overview of operation
// - Suspend completes within 30 us of accepting the suspend command.
// - Page program finishes typically in 2 ms, at most 3 ms.
// - Every erase finishes typically in 8 ms, at most 12 ms.
// - Status register reads all zero when delivered.
// - Power-up returns to standby; contents change only after valid command.
// - Commands whose bit count is not a multiple of eight are rejected.
// - Data-changing commands need the write latch set beforehand.
// - The five-bit range field marks a region that cannot change.
// - Protect pin low blocks writes to range and lock bits.
// - In deep power-down only the release command is obeyed.
// - Large-range codes protect none, 64/128/256 KB top/bottom, or all.
// - Small-range codes protect none, 4/8/16/32 KB top/bottom, or all.
// - Invert bit set protects the complement of the selected region.
module fwp_top
	import fwp_pkg::*;
#(
	parameter int PROG_TYP_CYC  = PROG_TYP_MS * CYC_PER_MS,
	parameter int PROG_MAX_CYC  = PROG_MAX_MS * CYC_PER_MS,
	parameter int ERASE_TYP_CYC = ERASE_TYP_MS * CYC_PER_MS,
	parameter int ERASE_MAX_CYC = ERASE_MAX_MS * CYC_PER_MS
)(
	input  wire logic              sys_clk_in,
	input  wire logic              resetn_in,
	input  wire logic              psel_in,
	input  wire logic              penable_in,
	input  wire logic              pwrite_in,
	input  wire logic [7:0]        paddr_in,
	input  wire logic [31:0]       pwdata_in,
	output logic      [31:0]       prdata_out,
	output logic                   pready_out,
	output logic                   pslverr_out,
	input  wire logic              spi_cs_n_in,
	input  wire logic              spi_sclk_in,
	input  wire logic              spi_mosi_in,
	input  wire logic              wp_n_in,
	output logic                   busy_out,
	output logic                   suspended_out,
	output logic                   prog_pulse_out,
	output logic                   erase_pulse_out,
	output logic      [ADDR_W-1:0] op_addr_out
);
	if (ERASE_MAX_CYC >= 2 ** OP_W || PROG_TYP_CYC < 1 || PROG_MAX_CYC < PROG_TYP_CYC ||
		ERASE_MAX_CYC < ERASE_TYP_CYC || ERASE_TYP_CYC < 1) begin : g_bad_timing
		$error("fwp_top: operation times do not fit the timer");
	end

	// Protected-region test: range field, invert bit, target address
	function automatic logic prot_hit(input logic [ADDR_W-1:0] a, input logic [4:0] r,
		input logic inv);
		logic [19:0] sz;
		logic        hit;
		sz = 20'h00000;
		if (!r[4]) begin
			if (r[2])
				sz = ARRAY_BYTES;
			else begin
				case (r[1:0])
					2'h1: sz = SZ_64K;
					2'h2: sz = SZ_128K;
					2'h3: sz = SZ_256K;
					default: sz = 20'h00000;
				endcase
			end
		end else begin
			case (r[2:0])
				3'h1: sz = SZ_4K;
				3'h2: sz = SZ_8K;
				3'h3: sz = SZ_16K;
				3'h4, 3'h5, 3'h6: sz = SZ_32K;
				3'h7: sz = ARRAY_BYTES;
				default: sz = 20'h00000;
			endcase
		end
		if (sz == ARRAY_BYTES)
			hit = 1'b1;
		else if (r[3])
			hit = {1'b0, a} < sz;
		else
			hit = {1'b0, a} >= ARRAY_BYTES - sz;
		return hit ^ inv;
	endfunction : prot_hit

	logic [3:0]        s1_q, s1_d, s2_q, s2_d;
	logic              cs_prev_q, cs_prev_d, sclk_prev_q, sclk_prev_d;
	logic [7:0]        sh_q, sh_d, opc_q, opc_d;
	logic [2:0]        bit_q, bit_d, byte_q, byte_d;
	logic [23:0]       addr_q, addr_d;
	fwp_st_e           st_q, st_d;
	logic [OP_W-1:0]   op_q, op_d;
	logic [SUS_W-1:0]  sus_q, sus_d;
	logic [2:0]        gap_q, gap_d;
	logic              latch_q, latch_d, inv_q, inv_d, dpd_q, dpd_d;
	logic [4:0]        rng_q, rng_d;
	logic [1:0]        lock_q, lock_d;
	logic              prog_q, prog_d, erase_q, erase_d, refused_q, refused_d;
	logic [ADDR_W-1:0] oaddr_q, oaddr_d;
	logic              busy_q, busy_d, susp_q, susp_d, ctrl_q, ctrl_d;
	logic [31:0]       prdata_q, prdata_d;
	logic              pready_q, pready_d, pslverr_q, pslverr_d;
	logic [15:0]       sr_view;
	logic              idle, blocked, frame_end, is_erase;
	logic [7:0]        lo, hi;

	always_comb begin
		s1_d        = {spi_cs_n_in, spi_sclk_in, spi_mosi_in, wp_n_in};
		s2_d        = s1_q;
		cs_prev_d   = s2_q[3];
		sclk_prev_d = s2_q[2];
		sh_d        = sh_q;
		bit_d       = bit_q;
		byte_d      = byte_q;
		opc_d       = opc_q;
		addr_d      = addr_q;
		st_d        = st_q;
		op_d        = op_q;
		sus_d       = sus_q;
		gap_d       = gap_q;
		latch_d     = latch_q;
		rng_d       = rng_q;
		lock_d      = lock_q;
		inv_d       = inv_q;
		dpd_d       = dpd_q;
		prog_d      = 1'b0;
		erase_d     = 1'b0;
		oaddr_d     = oaddr_q;
		refused_d   = refused_q;
		idle      = st_q == ST_IDLE;
		frame_end = s2_q[3] & ~cs_prev_q;
		lo        = (byte_q >= 3'h3) ? addr_q[15:8] : addr_q[7:0];
		hi        = addr_q[7:0];
		is_erase  = opc_q != OPC_PROG;
		if (opc_q == OPC_CHIP_A || opc_q == OPC_CHIP_B)
			blocked = prot_hit('0, rng_q, inv_q) | prot_hit('1, rng_q, inv_q);
		else
			blocked = prot_hit(addr_q[ADDR_W-1:0], rng_q, inv_q);
		if (gap_q != 3'h0)
			gap_d = gap_q - 3'h1;

		if (cs_prev_q & ~s2_q[3]) begin
			bit_d  = 3'h0;
			byte_d = 3'h0;
		end else if (~s2_q[3] & s2_q[2] & ~sclk_prev_q) begin
			sh_d  = {sh_q[6:0], s2_q[1]};
			bit_d = bit_q + 3'h1;
			if (bit_q == 3'h7) begin
				if (byte_q != 3'h4)
					byte_d = byte_q + 3'h1;
				if (byte_q == 3'h0)
					opc_d = sh_d;
				else if (byte_q != 3'h4)
					addr_d = {addr_q[15:0], sh_d};
			end
		end else if (frame_end && bit_q == 3'h0 && byte_q != 3'h0) begin
			if (dpd_q) begin
				if (opc_q == OPC_RELEASE)
					dpd_d = 1'b0;
			end else begin
				case (opc_q)
					OPC_UNLOCK: if (idle) latch_d = 1'b1;
					OPC_LOCK:   latch_d = 1'b0;
					OPC_SLEEP:  if (idle) dpd_d = 1'b1;
					OPC_WRSTAT: begin
						if (idle && latch_q && byte_q >= 3'h2) begin
							latch_d = 1'b0;
							if (byte_q >= 3'h3)
								inv_d = hi[6];
							if (s2_q[0]) begin
								rng_d     = lo[6:2];
								lock_d[0] = lo[7];
								if (byte_q >= 3'h3)
									lock_d[1] = hi[0];
							end
						end
					end
					OPC_PROG, OPC_ERS4K, OPC_ERS32K, OPC_ERS64K, OPC_CHIP_A, OPC_CHIP_B: begin
						if (idle && latch_q && (byte_q == 3'h4 || opc_q == OPC_CHIP_A ||
							opc_q == OPC_CHIP_B)) begin
							latch_d   = 1'b0;
							refused_d = blocked;
							oaddr_d   = addr_q[ADDR_W-1:0];
							if (!blocked) begin
								st_d    = ST_BUSY;
								prog_d  = !is_erase;
								erase_d = is_erase;
								if (is_erase)
									op_d = OP_W'((ctrl_q ? ERASE_MAX_CYC : ERASE_TYP_CYC) - 1);
								else
									op_d = OP_W'((ctrl_q ? PROG_MAX_CYC : PROG_TYP_CYC) - 1);
							end
						end
					end
					OPC_SUSPEND: begin
						if (st_q == ST_BUSY && gap_q == 3'h0) begin
							st_d  = ST_SUSPENDING;
							sus_d = SUS_W'(SUSP_LAT_CYC - 1);
						end
					end
					OPC_RESUME: begin
						if (st_q == ST_SUSPENDED) begin
							st_d  = ST_BUSY;
							gap_d = 3'(RES_GAP_CYC);
						end
					end
					default: ;
				endcase
			end
		end

		case (st_q)
			ST_BUSY: begin
				op_d = op_q - OP_W'(1);
				if (op_q == '0)
					st_d = ST_IDLE;
			end
			ST_SUSPENDING: begin
				sus_d = sus_q - SUS_W'(1);
				if (sus_q == '0)
					st_d = ST_SUSPENDED;
			end
			ST_IDLE, ST_SUSPENDED: ;
			default: st_d = ST_IDLE;
		endcase
		busy_d = st_d == ST_BUSY || st_d == ST_SUSPENDING;
		susp_d = st_d == ST_SUSPENDED;

		sr_view   = {1'b0, inv_q, 5'h00, lock_q[1], lock_q[0], rng_q, latch_q, busy_q};
		ctrl_d    = ctrl_q;
		prdata_d  = prdata_q;
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		if (psel_in & ~penable_in) begin
			pready_d = 1'b1;
			case (paddr_in)
				REG_STATUS: prdata_d = {14'h0000, dpd_q, susp_q, sr_view};
				REG_CTRL:   prdata_d = {31'h00000000, ctrl_q};
				REG_ADDR:   prdata_d = {7'h00, refused_q, 5'h00, oaddr_q};
				default: begin
					prdata_d  = 32'h00000000;
					pslverr_d = 1'b1;
				end
			endcase
		end
		if (psel_in & penable_in & pready_q & pwrite_in && paddr_in == REG_CTRL)
			ctrl_d = pwdata_in[0];
	end

	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			s1_q        <= 4'hF;
			s2_q        <= 4'hF;
			cs_prev_q   <= 1'b1;
			sclk_prev_q <= 1'b1;
			sh_q        <= 8'h00;
			opc_q       <= 8'h00;
			bit_q       <= 3'h0;
			byte_q      <= 3'h0;
			addr_q      <= 24'h000000;
			st_q        <= ST_IDLE;
			op_q        <= '0;
			sus_q       <= '0;
			gap_q       <= 3'h0;
			latch_q     <= 1'b0;
			inv_q       <= 1'b0;
			dpd_q       <= 1'b0;
			rng_q       <= RANGE_RST;
			lock_q      <= 2'h0;
			prog_q      <= 1'b0;
			erase_q     <= 1'b0;
			refused_q   <= 1'b0;
			oaddr_q     <= '0;
			busy_q      <= 1'b0;
			susp_q      <= 1'b0;
			ctrl_q      <= CTRL_RST;
			prdata_q    <= 32'h00000000;
			pready_q    <= 1'b0;
			pslverr_q   <= 1'b0;
		end else begin
			s1_q <= s1_d; s2_q <= s2_d; cs_prev_q <= cs_prev_d; sclk_prev_q <= sclk_prev_d;
			sh_q <= sh_d; opc_q <= opc_d; bit_q <= bit_d; byte_q <= byte_d;
			addr_q <= addr_d; st_q <= st_d; op_q <= op_d; sus_q <= sus_d; gap_q <= gap_d;
			latch_q <= latch_d; inv_q <= inv_d; dpd_q <= dpd_d; rng_q <= rng_d;
			lock_q <= lock_d; prog_q <= prog_d; erase_q <= erase_d;
			refused_q <= refused_d; oaddr_q <= oaddr_d;
			busy_q <= busy_d; susp_q <= susp_d; ctrl_q <= ctrl_d;
			prdata_q <= prdata_d; pready_q <= pready_d; pslverr_q <= pslverr_d;
		end
	end

	assign prdata_out      = prdata_q;
	assign pready_out      = pready_q;
	assign pslverr_out     = pslverr_q;
	assign busy_out        = busy_q;
	assign suspended_out   = susp_q;
	assign prog_pulse_out  = prog_q;
	assign erase_pulse_out = erase_q;
	assign op_addr_out     = oaddr_q;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);

	suspend_latency_a: assert property (
		$rose(st_q == ST_SUSPENDING) |-> ##[1:600] susp_q)
		else $error("suspend latency exceeded");
	prog_time_a: assert property (
		prog_q |-> st_q == ST_BUSY && op_q < OP_W'(PROG_MAX_CYC) && op_q >= OP_W'(PROG_TYP_CYC - 1))
		else $error("program time out of range");
	erase_time_a: assert property (
		erase_q |-> st_q == ST_BUSY && op_q < OP_W'(ERASE_MAX_CYC) && op_q >= OP_W'(ERASE_TYP_CYC - 1))
		else $error("erase time out of range");
	frame_bits_a: assert property (
		frame_end && bit_q != 3'h0 |=> !prog_q && !erase_q && $stable(rng_q))
		else $error("partial byte command acted on");
	latch_need_a: assert property (
		prog_q || erase_q |-> $past(latch_q) && !latch_q)
		else $error("array change without write latch");
	region_guard_a: assert property (
		prog_q || erase_q |-> !refused_q && $past(idle))
		else $error("protected address accepted");
	pin_guard_a: assert property (
		!s2_q[0] |=> $stable(rng_q) && $stable(lock_q))
		else $error("range bits changed with protect pin low");
	sleep_guard_a: assert property (
		dpd_q |=> !prog_q && !erase_q && $stable(latch_q) && $stable(rng_q))
		else $error("command obeyed in deep power-down");
endmodule : fwp_top

// *** sim/fwp_host.sv ***
// Host-side serial flash controller model: select, serial clock and data
module fwp_host (
	input  wire logic sys_clk_in,
	output logic      spi_cs_n_out,
	output logic      spi_sclk_out,
	output logic      spi_mosi_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		spi_cs_n_out = 1'b1;
		spi_sclk_out = 1'b0;
		spi_mosi_out = 1'b0;
	end
	// Select stays inactive until the supply has settled
	task automatic powerup();
		repeat (1400) @(posedge sys_clk_in);
	endtask : powerup
	// MSB first, clock idles low, 400 ns period; data inverted once deselected
	task automatic send(input logic [39:0] d, input int nbits);
		spi_cs_n_out <= 1'b0;
		repeat (4) @(posedge sys_clk_in);
		for (int i = 0; i < nbits; i++) begin
			spi_mosi_out <= d[39-i];
			repeat (4) @(posedge sys_clk_in);
			spi_sclk_out <= 1'b1;
			repeat (4) @(posedge sys_clk_in);
			spi_sclk_out <= 1'b0;
		end
		repeat (4) @(posedge sys_clk_in);
		spi_cs_n_out <= 1'b1;
		spi_mosi_out <= ~spi_mosi_out;
		// Gap after every command, so no suspend follows a resume too soon
		repeat (8) @(posedge sys_clk_in);
	endtask : send
endmodule : fwp_host

// *** sim/tb_top.sv ***
// Self-checking bench for the flash write-protect and suspend block
module tb_top
	import fwp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, psel, pen, pwr, wp_n, pready, perr, busy, susp, ppul, epul, err;
	logic cs_n, sclk, mosi;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [ADDR_W-1:0] opa;
	logic [25:0] tbl [14];
	logic [7:0] ers [5];
	int fail_count, n_checks, np, ne, bcnt, p0, b0, k;
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	fwp_top #(.PROG_TYP_CYC(40), .PROG_MAX_CYC(60), .ERASE_TYP_CYC(160), .ERASE_MAX_CYC(240))
	u_dut (
		.sys_clk_in(clk), .resetn_in(rst_n), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(perr), .spi_cs_n_in(cs_n), .spi_sclk_in(sclk),
		.spi_mosi_in(mosi), .wp_n_in(wp_n), .busy_out(busy), .suspended_out(susp),
		.prog_pulse_out(ppul), .erase_pulse_out(epul), .op_addr_out(opa)
	);
	fwp_host u_host (.sys_clk_in(clk), .spi_cs_n_out(cs_n), .spi_sclk_out(sclk),
		.spi_mosi_out(mosi));
	always @(posedge clk) begin
		if (ppul === 1'b1) np++;
		if (epul === 1'b1) ne++;
		if (busy === 1'b1) bcnt++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, "register read");
	endtask : rdc
	task automatic cmd(input logic [7:0] c, input logic [31:0] d, input int nb);
		u_host.send({c, d}, nb);
	endtask : cmd
	// Unlock first, then the data-changing command
	task automatic op(input logic [7:0] c, input logic [18:0] a, input int nb);
		cmd(OPC_UNLOCK, 32'h0, 8);
		cmd(c, {5'h00, a, 8'h00}, nb);
	endtask : op
	task automatic wrst(input logic [7:0] b1, input logic [7:0] b2);
		cmd(OPC_UNLOCK, 32'h0, 8);
		cmd(OPC_WRSTAT, {b1, b2, 16'h0}, 24);
	endtask : wrst
	task automatic idle();
		k = 0;
		while ((busy !== 1'b0 || susp !== 1'b0) && k < 3000) begin
			@(posedge clk);
			k++;
		end
		chk(32'(k < 3000), 32'h1, "idle wait");
	endtask : idle
	task automatic dur(input int t);
		chk(32'(bcnt - b0 >= t && bcnt - b0 <= t + 2), 32'h1, "busy length");
	endtask : dur
	task automatic finish_test();
		if (fail_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		finish_test();
	end
	initial begin
		{rst_n, psel, pen, pwr, paddr, pwdata} = '0;
		wp_n = 1'b1;
		{fail_count, n_checks, np, ne, bcnt} = '0;
		ers = '{OPC_ERS4K, OPC_ERS32K, OPC_ERS64K, OPC_CHIP_A, OPC_CHIP_B};
		// inverted, range field, target address, expected refusal
		tbl = '{{1'b0, 5'h01, 19'h70000, 1'b1}, {1'b0, 5'h01, 19'h6FFFF, 1'b0},
			{1'b0, 5'h09, 19'h0FFFF, 1'b1}, {1'b0, 5'h09, 19'h10000, 1'b0},
			{1'b0, 5'h04, 19'h00000, 1'b1}, {1'b0, 5'h11, 19'h7F000, 1'b1},
			{1'b0, 5'h11, 19'h7EFFF, 1'b0}, {1'b0, 5'h12, 19'h7E000, 1'b1},
			{1'b0, 5'h1C, 19'h07FFF, 1'b1}, {1'b0, 5'h17, 19'h40000, 1'b1},
			{1'b1, 5'h00, 19'h12345, 1'b1}, {1'b1, 5'h01, 19'h70000, 1'b0},
			{1'b1, 5'h01, 19'h00000, 1'b1}, {1'b0, 5'h00, 19'h7FFFF, 1'b0}};
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(REG_STATUS, 32'h0);
		rdc(REG_CTRL, 32'h0);
		apb(1'b1, 8'h0C, 32'h1);
		chk({31'h0, err}, 32'h1, "unmapped error");
		apb(1'b1, REG_STATUS, 32'hFFFFFFFF);
		rdc(REG_STATUS, 32'h0);
		u_host.powerup();
		p0 = np;
		cmd(OPC_PROG, 32'h00010000, 32);
		chk(32'(np - p0), 32'h0, "program without unlock");
		cmd(OPC_UNLOCK, 32'h0, 8);
		cmd(OPC_PROG, 32'h00010000, 31);
		rdc(REG_STATUS, 32'h2);
		b0 = bcnt;
		cmd(OPC_PROG, 32'h00010000, 32);
		idle();
		chk(32'(np - p0), 32'h1, "program pulse");
		dur(40);
		rdc(REG_ADDR, 32'h100);
		apb(1'b1, REG_CTRL, 32'h1);
		rdc(REG_CTRL, 32'h1);
		b0 = bcnt;
		op(OPC_PROG, 19'h200, 32);
		idle();
		dur(60);
		apb(1'b1, REG_CTRL, 32'h0);
		for (int i = 0; i < 5; i++) begin
			p0 = ne;
			b0 = bcnt;
			op(ers[i], 19'h20000, (i < 3) ? 32 : 8);
			idle();
			chk(32'(ne - p0), 32'h1, "erase pulse");
			dur(160);
		end
		apb(1'b1, REG_CTRL, 32'h1);
		op(OPC_ERS4K, 19'h30000, 32);
		cmd(OPC_SUSPEND, 32'h0, 8);
		k = 0;
		while (susp !== 1'b1 && k < 700) begin
			@(posedge clk);
			k++;
		end
		chk(32'(k >= 580 && k <= 600), 32'h1, "suspend latency");
		rdc(REG_STATUS, 32'h00010000);
		// No new suspend before the operation ends, so the run after resume is long
		cmd(OPC_RESUME, 32'h0, 8);
		idle();
		apb(1'b1, REG_CTRL, 32'h0);
		for (int i = 0; i < 14; i++) begin
			wrst({1'b0, tbl[i][24:20], 2'b00}, {1'b0, tbl[i][25], 6'h00});
			idle();
			p0 = np;
			op(OPC_PROG, tbl[i][19:1], 32);
			idle();
			apb(1'b0, REG_ADDR, 32'h0);
			chk(rd & 32'h0107FFFF, {7'h0, tbl[i][0], 5'h0, tbl[i][19:1]}, "refusal");
			chk({13'h0, opa}, {13'h0, tbl[i][19:1]}, "op address");
			chk(32'(np - p0), 32'(!tbl[i][0]), "range");
		end
		wrst(8'h88, 8'h41);
		idle();
		rdc(REG_STATUS, 32'h00004188);
		wp_n <= 1'b0;
		wrst(8'h00, 8'h00);
		idle();
		rdc(REG_STATUS, 32'h00000188);
		wp_n <= 1'b1;
		wrst(8'h00, 8'h00);
		idle();
		cmd(OPC_SLEEP, 32'h0, 8);
		p0 = np;
		op(OPC_PROG, 19'h100, 32);
		rdc(REG_STATUS, 32'h00020000);
		cmd(OPC_RELEASE, 32'h0, 8);
		op(OPC_PROG, 19'h100, 32);
		idle();
		chk(32'(np - p0), 32'h1, "sleep gating");
		// Reset in mid-program must bring the block back to standby
		op(OPC_PROG, 19'h100, 32);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(REG_STATUS, 32'h0);
		rdc(REG_ADDR, 32'h0);
		finish_test();
	end
endmodule : tb_top
